// >>> logic/swe_pkg.sv
package swe_pkg;
   // Switch inputs watched and the count that shares the common limit
   localparam int NUM_IN        = 24;
   localparam int SHARED_INPUTS = 12;
   localparam int NUM_OTHER     = 2;
   localparam int FLAG_W        = NUM_IN + 1 + NUM_OTHER;
   localparam int FLAG_SHARED   = NUM_IN;
   localparam int FLAG_OTHER_LO = NUM_IN + 1;

   // Device clock and window lengths; least times, so cycle counts round up
   localparam int CLK_PERIOD_NS          = 50;
   localparam int ACTIVE_WINDOW_TIME_NS  = 2000;
   localparam int RELEASE_WINDOW_TIME_NS = 2000;
   localparam int IDLE_GAP_TIME_NS       = 1000;
   localparam int ACTIVE_CYC  = (ACTIVE_WINDOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_CYC = (RELEASE_WINDOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_CYC    = (IDLE_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W       = 16;

   // Scheme select values
   localparam logic SCHEME_STATIC  = 1'b0;
   localparam logic SCHEME_DYNAMIC = 1'b1;

   // Edge condition codes per input
   localparam logic [1:0] COND_OFF  = 2'h0;
   localparam logic [1:0] COND_RISE = 2'h1;
   localparam logic [1:0] COND_FALL = 2'h2;
   localparam logic [1:0] COND_BOTH = 2'h3;

   // Debounce depth: 0 means any crossing, 3 means four stable cycles
   localparam int         DEB_W     = 2;
   localparam logic [1:0] DEB_RESET = 2'h0;

   typedef enum logic [1:0] {
      SWE_ST_IDLE,
      SWE_ST_LOW,
      SWE_ST_HIGH,
      SWE_ST_GAP
   } swe_state_e;
endpackage

// >>> logic/swe_debounce.sv
module swe_debounce
   import swe_pkg::*;
(
   input  wire logic             clk_in,    // Device clock
   input  wire logic             rst_in,    // Async reset, active high
   input  wire logic             run_in,    // Monitoring runs
   input  wire logic             poll_in,   // One detection cycle done
   input  wire logic             above_in,  // Status versus threshold
   input  wire logic [DEB_W-1:0] depth_in,  // Debounce depth
   output logic                  evt_out,   // Filtered crossing pulse
   output logic                  base_out,  // Baseline stored pulse
   output logic                  stable_out // Accepted status
);
   logic             based_reg;
   logic [DEB_W-1:0] cnt_reg;
   logic [DEB_W:0]   need;
   logic [DEB_W:0]   cnt_inc;

   assign need    = {1'b0, depth_in} + (DEB_W+1)'(1);
   assign cnt_inc = {1'b0, cnt_reg} + (DEB_W+1)'(1);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         based_reg  <= 1'b0;
         stable_out <= 1'b0;
         cnt_reg    <= '0;
         evt_out    <= 1'b0;
         base_out   <= 1'b0;
      end else begin
         evt_out  <= 1'b0;
         base_out <= 1'b0;
         if (!run_in) begin
            cnt_reg   <= '0;
            based_reg <= 1'b0;
         end else if (poll_in) begin
            if (!based_reg) begin
               // First cycle sets the baseline and reports it regardless of depth
               based_reg  <= 1'b1;
               stable_out <= above_in;
               base_out   <= 1'b1;
               cnt_reg    <= '0;
            end else if (above_in == stable_out) begin
               cnt_reg <= '0;
            end else if (cnt_inc >= need) begin
               stable_out <= above_in;
               evt_out    <= 1'b1;
               cnt_reg    <= '0;
            end else begin
               cnt_reg <= cnt_inc[DEB_W-1:0];
            end
         end
      end
   end

   property p_deb_clear;
      @(posedge clk_in) disable iff (rst_in) !run_in |=> cnt_reg == '0 && !evt_out;
   endproperty
   a_deb_clear: assert property (p_deb_clear) else $error("debounce count not cleared");

   property p_deb_depth;
      @(posedge clk_in) disable iff (rst_in) evt_out |-> $past(cnt_inc) == $past(need);
   endproperty
   a_deb_depth: assert property (p_deb_depth) else $error("event before debounce depth");
endmodule // swe_debounce

// >>> logic/swe_event_irq.sv
// Contract
// - Request line is active-low open drain, pulled low on events, else released.
// - One configuration bit picks static (0) or dynamic toggling (1) scheme.
// - Static: line stays low until a transaction reading the flags ends.
// - Flags snapshot on first serial clock rise after select falls; read clears.
// - Dynamic: low for active window, released for release window, repeats until read.
// - Dynamic: read in low phase releases; read in high phase stops re-assertion.
// - Static scheme after reset; scheme changes only while monitoring is stopped.
// - Read with pending event starts idle gap; line stays released during it.
// - Second read inside the gap clears flags; no re-assertion at gap end.
// - Monitoring and events continue while serial supply is absent.
// - Per-input comparator and ADC enables plus separate shared-limit enable.
// - Rising condition: above now, below before, raises an event.
// - Falling condition: below now, above before, raises an event.
// - Both-edges condition: any crossing between measurements raises an event.
// - State change events disabled for every input after reset.
// - Two-bit debounce: any crossing, or 2, 3, 4 stable cycles.
// - Baseline stored at first detection cycle, flagged and requested then.
// - Debounce value 11 needs four stable detection cycles.
// - Debounce applies to all enabled inputs, never to shared-limit events.
// - Debounce counters return to zero when monitoring stops.
// - After reset the debounce setting reports every crossing.
module swe_event_irq
   import swe_pkg::*;
#(
   parameter int ACTIVE_CYCLES  = swe_pkg::ACTIVE_CYC,
   parameter int RELEASE_CYCLES = swe_pkg::RELEASE_CYC,
   parameter int IDLE_CYCLES    = swe_pkg::IDLE_CYC
) (
   input  wire logic                            CLK_IN,                 // Device clock
   input  wire logic                            RST_IN,                 // Async reset
   input  wire logic                            IO_SUPPLY_OK_IN,        // Serial supply pin
   input  wire logic                            CS_N_IN,                // Chip select pin
   input  wire logic                            SCLK_IN,                // Serial clock pin
   input  wire logic                            FLAG_READ_IN,           // Flag read decoded
   input  wire logic                            SCHEME_SEL_IN,          // 0 static, 1 dynamic
   input  wire logic                            RUN_IN,                 // Monitoring runs
   input  wire logic [swe_pkg::DEB_W-1:0]       DEBOUNCE_DEPTH_IN,      // Debounce depth
   input  wire logic [swe_pkg::NUM_IN-1:0]      ADC_MODE_IN,            // 1 ADC, 0 comparator
   input  wire logic [swe_pkg::NUM_IN-1:0]      COMP_EVENT_ENABLE_IN,   // Comparator enables
   input  wire logic [swe_pkg::NUM_IN-1:0]      ADC_EVENT_ENABLE_IN,    // ADC enables
   input  wire logic [2*swe_pkg::NUM_IN-1:0]    EDGE_COND_IN,           // Condition per input
   input  wire logic                            SHARED_EVENT_ENABLE_IN, // Shared limit enable
   input  wire logic [1:0]                      SHARED_COND_IN,         // Shared condition
   input  wire logic                            POLL_DONE_IN,           // Detection cycle pulse
   input  wire logic [swe_pkg::NUM_IN-1:0]      STATUS_ABOVE_IN,        // Above own threshold
   input  wire logic                            SHARED_ABOVE_IN,        // Any above shared limit
   input  wire logic [swe_pkg::NUM_OTHER-1:0]   OTHER_EVENT_IN,         // Other event pulses
   output logic                                 EVT_REQ_OUT,            // Request pin value
   output logic                                 EVT_REQ_OE_OUT,         // Request pin pull low
   output logic [swe_pkg::FLAG_W-1:0]           FLAGS_OUT,              // Event flag register
   output logic [swe_pkg::FLAG_W-1:0]           FLAG_SNAP_OUT,          // Snapshot for readout
   output logic                                 SCHEME_OUT              // Scheme in force
);
   localparam int N = NUM_IN;

   logic [1:0]       cs_sync_reg;
   logic [1:0]       sclk_sync_reg;
   logic             sclk_prev_reg;
   logic [1:0]       io_sync_reg;
   logic             cs_eff;
   logic             cs_prev_reg;
   logic             cs_rise;
   logic             cs_fall;
   logic             sclk_rise;
   logic             armed_reg;
   logic             rd_pend_reg;
   logic             read_done;
   logic             scheme_reg;
   logic [DEB_W-1:0] depth_reg;
   logic [N-1:0]     en_reg;
   logic [2*N-1:0]   cond_reg;
   logic             shared_en_reg;
   logic             shared_prev_reg;
   logic             shared_based_reg;
   logic             shared_set;
   logic [N-1:0]     deb_evt;
   logic [N-1:0]     deb_base;
   logic [N-1:0]     deb_stable;
   logic [N-1:0]     ssc_set;
   logic [FLAG_W-1:0] set_vec;
   logic [FLAG_W-1:0] flags_reg;
   logic [FLAG_W-1:0] snap_reg;
   logic             pending;
   logic             new_evt;
   swe_state_e       state_reg;
   logic [TMR_W-1:0] tmr_reg;
   logic             skip_reg;

   // Pins cross into the device clock; the serial clock edges are found by sampling
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cs_sync_reg   <= 2'h3;
         sclk_sync_reg <= 2'h0;
         sclk_prev_reg <= 1'b0;
         io_sync_reg   <= 2'h0;
      end else begin
         cs_sync_reg   <= {cs_sync_reg[0], CS_N_IN};
         sclk_sync_reg <= {sclk_sync_reg[0], SCLK_IN};
         sclk_prev_reg <= sclk_sync_reg[1];
         io_sync_reg   <= {io_sync_reg[0], IO_SUPPLY_OK_IN};
      end
   end

   // Without serial supply the select is seen as idle; events still flow
   assign cs_eff    = cs_sync_reg[1] | ~io_sync_reg[1];
   assign cs_rise   = cs_eff & ~cs_prev_reg;
   assign cs_fall   = ~cs_eff & cs_prev_reg;
   assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
   assign read_done = cs_rise & rd_pend_reg;

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cs_prev_reg <= 1'b1;
         armed_reg   <= 1'b0;
         rd_pend_reg <= 1'b0;
      end else begin
         cs_prev_reg <= cs_eff;
         if (cs_fall) begin
            armed_reg <= 1'b1;
         end else if (sclk_rise && !cs_eff) begin
            armed_reg <= 1'b0;
         end
         if (cs_rise) begin
            rd_pend_reg <= 1'b0;
         end else if (!cs_eff && FLAG_READ_IN) begin
            rd_pend_reg <= 1'b1;
         end
      end
   end

   // Snapshot is what the host reads; only those bits are cleared later
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         snap_reg <= '0;
      end else if (armed_reg && sclk_rise && !cs_eff) begin
         snap_reg <= flags_reg;
      end
   end

   // Configuration capture
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         scheme_reg    <= SCHEME_STATIC;
         depth_reg     <= DEB_RESET;
         en_reg        <= '0;
         cond_reg      <= '0;
         shared_en_reg <= 1'b0;
      end else begin
         if (!RUN_IN) begin
            scheme_reg <= SCHEME_SEL_IN;
         end
         depth_reg     <= DEBOUNCE_DEPTH_IN;
         en_reg        <= (ADC_MODE_IN & ADC_EVENT_ENABLE_IN)
                        | (~ADC_MODE_IN & COMP_EVENT_ENABLE_IN);
         cond_reg      <= EDGE_COND_IN;
         shared_en_reg <= SHARED_EVENT_ENABLE_IN;
      end
   end

   // Per-input filter and condition; the filter sees every input, gating comes after
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_in
         logic [1:0] cond;
         logic       hit;
         assign cond = cond_reg[2*gi +: 2];
         assign hit  = (cond == COND_BOTH)
                     | ((cond == COND_RISE) & deb_stable[gi])
                     | ((cond == COND_FALL) & ~deb_stable[gi]);
         assign ssc_set[gi] = en_reg[gi] & (deb_base[gi] | (deb_evt[gi] & hit));

         swe_debounce u_deb (
            .clk_in     (CLK_IN),
            .rst_in     (RST_IN),
            .run_in     (RUN_IN),
            .poll_in    (POLL_DONE_IN),
            .above_in   (STATUS_ABOVE_IN[gi]),
            .depth_in   (depth_reg),
            .evt_out    (deb_evt[gi]),
            .base_out   (deb_base[gi]),
            .stable_out (deb_stable[gi])
         );
      end
   endgenerate

   // Shared limit compares raw successive measurements, no debounce
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         shared_prev_reg  <= 1'b0;
         shared_based_reg <= 1'b0;
      end else if (!RUN_IN) begin
         shared_based_reg <= 1'b0;
      end else if (POLL_DONE_IN) begin
         shared_prev_reg  <= SHARED_ABOVE_IN;
         shared_based_reg <= 1'b1;
      end
   end

   always_comb begin
      shared_set = 1'b0;
      if (RUN_IN && POLL_DONE_IN && shared_based_reg && shared_en_reg) begin
         case (SHARED_COND_IN)
            COND_RISE: shared_set = SHARED_ABOVE_IN & ~shared_prev_reg;
            COND_FALL: shared_set = ~SHARED_ABOVE_IN & shared_prev_reg;
            COND_BOTH: shared_set = SHARED_ABOVE_IN ^ shared_prev_reg;
            default:   shared_set = 1'b0;
         endcase
      end
   end

   assign set_vec = {OTHER_EVENT_IN, shared_set, ssc_set};
   assign new_evt = |set_vec;
   assign pending = |flags_reg;

   // A new event in the clearing cycle survives: set is applied after the clear
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         flags_reg <= '0;
      end else if (read_done) begin
         flags_reg <= (flags_reg & ~snap_reg) | set_vec;
      end else begin
         flags_reg <= flags_reg | set_vec;
      end
   end

   // Request sequencer; one down-counter serves all three windows
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_reg <= SWE_ST_IDLE;
         tmr_reg   <= '0;
         skip_reg  <= 1'b0;
      end else begin
         case (state_reg)
            SWE_ST_IDLE: begin
               skip_reg <= 1'b0;
               if (new_evt) begin
                  state_reg <= SWE_ST_LOW;
                  tmr_reg   <= TMR_W'(ACTIVE_CYCLES - 1);
               end
            end
            SWE_ST_LOW: begin
               if (read_done) begin
                  state_reg <= SWE_ST_GAP;
                  tmr_reg   <= TMR_W'(IDLE_CYCLES - 1);
                  skip_reg  <= 1'b0;
               end else if (scheme_reg == SCHEME_DYNAMIC && tmr_reg == '0) begin
                  state_reg <= SWE_ST_HIGH;
                  tmr_reg   <= TMR_W'(RELEASE_CYCLES - 1);
               end else if (tmr_reg != '0) begin
                  tmr_reg <= tmr_reg - TMR_W'(1);
               end
            end
            SWE_ST_HIGH: begin
               if (read_done) begin
                  state_reg <= SWE_ST_GAP;
                  tmr_reg   <= TMR_W'(IDLE_CYCLES - 1);
                  skip_reg  <= 1'b1;
               end else if (tmr_reg == '0) begin
                  state_reg <= SWE_ST_LOW;
                  tmr_reg   <= TMR_W'(ACTIVE_CYCLES - 1);
               end else begin
                  tmr_reg <= tmr_reg - TMR_W'(1);
               end
            end
            SWE_ST_GAP: begin
               if (tmr_reg == '0) begin
                  // Events that came in the gap are asserted now unless read again or the gap began with a high-phase read
                  if (pending && !skip_reg && !read_done) begin
                     state_reg <= SWE_ST_LOW;
                     tmr_reg   <= TMR_W'(ACTIVE_CYCLES - 1);
                  end else begin
                     state_reg <= SWE_ST_IDLE;
                  end
                  skip_reg <= 1'b0;
               end else begin
                  tmr_reg <= tmr_reg - TMR_W'(1);
                  if (read_done) begin
                     skip_reg <= 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= SWE_ST_IDLE;
            end
         endcase
      end
   end

   // Open drain: value is always low, the enable does the pulling
   assign EVT_REQ_OUT    = 1'b0;
   assign EVT_REQ_OE_OUT = (state_reg == SWE_ST_LOW);
   assign FLAGS_OUT      = flags_reg;
   assign FLAG_SNAP_OUT  = snap_reg;
   assign SCHEME_OUT     = scheme_reg;

   property p_req_cause;
      @(posedge CLK_IN) disable iff (RST_IN) EVT_REQ_OE_OUT |-> pending && !EVT_REQ_OUT;
   endproperty
   a_req_cause: assert property (p_req_cause) else $error("request low without flag");

   property p_static_hold;
      @(posedge CLK_IN) disable iff (RST_IN)
         state_reg == SWE_ST_LOW && scheme_reg == SCHEME_STATIC && !read_done
         |=> state_reg == SWE_ST_LOW;
   endproperty
   a_static_hold: assert property (p_static_hold) else $error("static request released");

   property p_snap;
      @(posedge CLK_IN) disable iff (RST_IN)
         armed_reg && sclk_rise && !cs_eff |=> snap_reg == $past(flags_reg) && !armed_reg;
   endproperty
   a_snap: assert property (p_snap) else $error("flag snapshot missed");

   property p_dyn_active;
      @(posedge CLK_IN) disable iff (RST_IN)
         state_reg == SWE_ST_LOW && tmr_reg != '0 && !read_done |=> state_reg == SWE_ST_LOW;
   endproperty
   a_dyn_active: assert property (p_dyn_active) else $error("active window cut short");

   property p_dyn_reassert;
      @(posedge CLK_IN) disable iff (RST_IN)
         state_reg == SWE_ST_HIGH && tmr_reg == '0 && !read_done |=> EVT_REQ_OE_OUT;
   endproperty
   a_dyn_reassert: assert property (p_dyn_reassert) else $error("no re-assertion");

   property p_high_read;
      @(posedge CLK_IN) disable iff (RST_IN)
         state_reg == SWE_ST_HIGH && read_done |=> state_reg == SWE_ST_GAP && skip_reg;
   endproperty
   a_high_read: assert property (p_high_read) else $error("high phase read mishandled");

   property p_scheme_frozen;
      @(posedge CLK_IN) disable iff (RST_IN) RUN_IN |=> $stable(scheme_reg);
   endproperty
   a_scheme_frozen: assert property (p_scheme_frozen) else $error("scheme changed in run");

   property p_gap_released;
      @(posedge CLK_IN) disable iff (RST_IN)
         state_reg == SWE_ST_LOW && read_done |=> state_reg == SWE_ST_GAP && !EVT_REQ_OE_OUT;
   endproperty
   a_gap_released: assert property (p_gap_released) else $error("no idle gap after read");

   property p_gap_skip;
      @(posedge CLK_IN) disable iff (RST_IN)
         state_reg == SWE_ST_GAP && skip_reg && tmr_reg == '0 |=> state_reg == SWE_ST_IDLE;
   endproperty
   a_gap_skip: assert property (p_gap_skip) else $error("re-asserted after gap read");

   property p_set_wins;
      @(posedge CLK_IN) disable iff (RST_IN)
         read_done |=> (flags_reg & $past(set_vec)) == $past(set_vec);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   c_dyn_toggle: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      state_reg == SWE_ST_HIGH ##1 state_reg == SWE_ST_LOW);
   c_static_read: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      scheme_reg == SCHEME_STATIC && state_reg == SWE_ST_LOW && read_done);
   c_gap_skip: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      state_reg == SWE_ST_GAP && read_done);
   c_shared_evt: cover property (@(posedge CLK_IN) disable iff (RST_IN) shared_set);
endmodule // swe_event_irq

// >>> verif/swe_host_model.sv
module swe_host_model (
   output logic cs_n_out,     // Chip select, active low
   output logic sclk_out,     // Serial clock, idle low
   output logic flag_read_out // Flag register read decoded
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      flag_read_out = 1'b0;
   end
   // Serial clock stands still outside frames
   task automatic xfer(input logic rd);
      cs_n_out = 1'b0;
      #400;
      repeat (4) begin
         sclk_out = 1'b1;
         #200;
         sclk_out = 1'b0;
         #200;
      end
      flag_read_out = rd;
      #400;
      flag_read_out = 1'b0;
      #200;
      cs_n_out = 1'b1;
      #400;
   endtask
endmodule // swe_host_model

// >>> verif/swe_event_irq_bench.sv
module swe_event_irq_bench;
   import swe_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int ACT = 6, REL = 6, IDL = 150;
   logic clk_in = 1'b0, rst_in = 1'b1, run = 1'b0, sel = 1'b0, poll_q = 1'b0, sh_above = 1'b0;
   logic sh_en = 1'b0, io_ok = 1'b1, sp;
   logic [1:0] depth = 2'h0, other = 2'h0, sh_cond = 2'h0;
   logic [NUM_IN-1:0] above = '0, adc_mode = '0, en = '0;
   logic [2*NUM_IN-1:0] edge_cond = '0;
   logic cs_n, sclk, frd, oe, req, scheme, lvl;
   logic [FLAG_W-1:0] flags, snap;
   logic [31:0] seed = 32'h91fd;
   int num_errors = 0, num_checks = 0, idx, n;
   always #25 clk_in = ~clk_in;
   swe_host_model swe_host_model_inst (.cs_n_out(cs_n), .sclk_out(sclk), .flag_read_out(frd));
   swe_event_irq #(.ACTIVE_CYCLES(ACT), .RELEASE_CYCLES(REL), .IDLE_CYCLES(IDL)) swe_event_irq_inst (
      .CLK_IN(clk_in), .RST_IN(rst_in), .IO_SUPPLY_OK_IN(io_ok), .CS_N_IN(cs_n), .SCLK_IN(sclk),
      .FLAG_READ_IN(frd), .SCHEME_SEL_IN(sel), .RUN_IN(run), .DEBOUNCE_DEPTH_IN(depth),
      .ADC_MODE_IN(adc_mode), .COMP_EVENT_ENABLE_IN(en), .ADC_EVENT_ENABLE_IN(en),
      .EDGE_COND_IN(edge_cond), .SHARED_EVENT_ENABLE_IN(sh_en), .SHARED_COND_IN(sh_cond),
      .POLL_DONE_IN(poll_q), .STATUS_ABOVE_IN(above), .SHARED_ABOVE_IN(sh_above),
      .OTHER_EVENT_IN(other), .EVT_REQ_OUT(req), .EVT_REQ_OE_OUT(oe), .FLAGS_OUT(flags),
      .FLAG_SNAP_OUT(snap), .SCHEME_OUT(scheme));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic exp_evt(input logic [1:0] c, input logic o, input logic v);
      return (v & ~o & c[0]) | (~v & o & c[1]);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic poll(input logic v);
      @(negedge clk_in);
      seed = lfsr_next(seed);
      above = seed[NUM_IN-1:0];
      above[idx] = v;
      sh_above = seed[31];
      poll_q = 1'b1;
      @(negedge clk_in);
      poll_q = 1'b0;
      repeat (3) @(negedge clk_in);
   endtask
   task automatic pulse(input logic [1:0] v);
      @(negedge clk_in);
      other = v;
      @(negedge clk_in);
      other = 2'h0;
      repeat (2) @(negedge clk_in);
   endtask
   task automatic rd;
      swe_host_model_inst.xfer(1'b1);
      repeat (4) @(negedge clk_in);
   endtask
   // Waits while the pull-down enable equals v; n returns the cycles spent
   task automatic wait_oe(input logic v);
      n = 0;
      while (oe === v && n < 500) begin
         n++;
         @(negedge clk_in);
      end
   endtask
   initial begin
      seed = lfsr_next(seed);
      idx = seed % NUM_IN;
      adc_mode = seed[NUM_IN-1:0];
      en[idx] = 1'b1;
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      check(oe, 0);
      check(req, 0);
      check(32'(flags), 0);
      check(scheme, SCHEME_STATIC);
      run = 1'b1;
      lvl = 1'b0;
      poll(lvl);
      check(flags[idx], 1);
      check(oe, 1);
      swe_host_model_inst.xfer(1'b0);
      check(oe, 1);
      rd;
      check(32'(flags), 0);
      check(oe, 0);
      check(snap[idx], 1);
      $display("static scheme done");
      for (int c = 1; c < 4; c++) begin
         edge_cond[2*idx +: 2] = 2'(c);
         repeat (2) begin
            poll(~lvl);
            check(flags[idx], exp_evt(2'(c), lvl, ~lvl));
            lvl = ~lvl;
            rd;
         end
      end
      depth = 2'h3;
      for (int k = 1; k < 5; k++) begin
         poll(~lvl);
         check(flags[idx], k == 4);
      end
      lvl = ~lvl;
      rd;
      $display("conditions and debounce done");
      pulse(2'h1);
      rd;
      pulse(2'h2);
      check(flags[FLAG_OTHER_LO+1], 1);
      check(oe, 0);
      rd;
      check(32'(flags), 0);
      repeat (IDL + 10) @(negedge clk_in);
      check(oe, 0);
      pulse(2'h1);
      rd;
      pulse(2'h2);
      wait_oe(1'b0);
      check(oe, 1);
      rd;
      $display("idle gap done");
      run = 1'b0;
      sel = SCHEME_DYNAMIC;
      repeat (3) @(negedge clk_in);
      check(scheme, SCHEME_DYNAMIC);
      run = 1'b1;
      sel = SCHEME_STATIC;
      repeat (3) @(negedge clk_in);
      check(scheme, SCHEME_DYNAMIC);
      repeat (IDL) @(negedge clk_in);
      // Count the active window from the cycle right after the request rises
      other = 2'h1;
      @(negedge clk_in);
      other = 2'h0;
      wait_oe(1'b1);
      check(n, ACT);
      wait_oe(1'b0);
      check(n, REL);
      rd;
      repeat (IDL + 2 * ACT) @(negedge clk_in);
      check(oe, 0);
      check(32'(flags), 0);
      $display("dynamic scheme done");
      // Shared limit under four-cycle debounce must still report at once
      sh_en = 1'b1;
      poll(lvl);
      repeat (6) begin
         sp = sh_above;
         sh_cond = seed[5:4];
         poll(lvl);
         check(flags[FLAG_SHARED], exp_evt(sh_cond, sp, sh_above));
         rd;
      end
      $display("shared limit done");
      io_ok = 1'b0;
      repeat (3) @(negedge clk_in);
      pulse(2'h1);
      rd;
      check(flags[FLAG_OTHER_LO], 1);
      io_ok = 1'b1;
      repeat (3) @(negedge clk_in);
      rd;
      check(flags[FLAG_OTHER_LO], 0);
      $display("serial supply loss done");
      print_verdict;
   end
   initial begin
      #2000000;
      num_errors++;
      print_verdict;
   end
endmodule // swe_event_irq_bench
